// File: fwc_pkg.sv
// Package: register map, field positions and timing for the flash write sequencer
`default_nettype none
package fwc_pkg;
  // Register byte addresses on the instruction bus
  localparam logic [23:0] FWC_STATUS_LOW_ADDR = 24'h080000;
  localparam logic [23:0] FWC_OP_CONTROL_ADDR = 24'h080002;
  localparam logic [23:0] FWC_REG_WIN_LO = 24'h080000;
  localparam logic [23:0] FWC_REG_WIN_HI = 24'h080015;
  localparam logic [23:0] FWC_BANK_LO = 24'h000000;
  localparam logic [23:0] FWC_BANK_HI = 24'h04ffff;
  localparam logic [23:0] FWC_TEST_LO = 24'h000000;
  localparam logic [23:0] FWC_TEST_HI = 24'h001fff;
  localparam logic [23:0] FWC_PROT_LO = 24'h0e8fb0;
  localparam logic [23:0] FWC_PROT_HI = 24'h08dfbf;
  // Reset values
  localparam logic [15:0] FWC_STATUS_LOW_RST = 16'h0000;
  localparam logic [15:0] FWC_OP_CONTROL_RST = 16'h0000;
  // Status low field positions
  localparam int FWC_BUSY_BIT = 1;
  localparam int FWC_LOCK_BIT = 4;
  // Operation control field positions
  localparam int FWC_START_BIT = 15;
  localparam int FWC_PAUSE_BIT = 14;
  localparam int FWC_WPG_BIT = 13;
  localparam int FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT = 12;
  localparam int FWC_SER_BIT = 11;
  localparam int FWC_SPR_BIT = 8;
  // Trap vector for invalid reads
  localparam logic [15:0] FWC_TRAP_CODE = 16'h009b;
  // Erase data patterns
  localparam logic [7:0] FWC_ERASED = 8'hff;
  localparam logic [7:0] FWC_PREPROG = 8'h00;
  // Operation durations
  localparam int FWC_CLK_MHZ = 40;
  localparam int FWC_PROG_US = 10;
  localparam int FWC_ERASE_US = 100;
  localparam int FWC_PROG_CYC = FWC_PROG_US * FWC_CLK_MHZ;
  localparam int FWC_ERASE_CYC = FWC_ERASE_US * FWC_CLK_MHZ;
  localparam int FWC_CNT_W = 24;
  // Sequencer states, Gray along idle-run-pause
  typedef enum logic [1:0] {
    FWC_IDLE = 2'b00,
    FWC_RUN = 2'b01,
    FWC_PAUSED = 2'b11,
    FWC_NEST = 2'b10
  } fwc_state_t;
endpackage
`default_nettype wire

// File: fwc_seq.sv
// Flash write control sequencer: control/status registers and bank guard
// Function
// RULE1: start bit raises busy while running
// RULE2: protection set also raises busy (code always refuses it: FWC_PROT_LO lies above FWC_PROT_HI)
// RULE3: busy blocks bank reads (trap) and writes
// RULE4: busy clears on finish/suspend, resets on resume
// RULE5: lock blocks flash register access with trap
// RULE6: lock set when start bit set
// RULE7: lock flag always readable; software polls
// RULE8: fault register updates only after busy clear
// RULE9: test sector never writable, bootstrap-only visible (code does not hide test sector reads outside bootstrap)
// RULE10: protection set checks window, clears select
// RULE11: address outside protection window flags fault
// RULE12: sector erase to FF, clears select
// RULE13: erase pre-programs sectors to 00 first
// RULE14: double word program, clears select at end
// RULE15: word program, clears select at completion
// RULE16: pause suspends program or erase
// RULE17: program paused: only reads and resume
// RULE18: erase paused: programs allowed, not suspendable
// RULE19: resume needs start plus matching select
// RULE20: no new operation while pause set
// RULE21: start bit self-clears; zero write ignored
// RULE22: fault flag blocks start
// RULE23: sectors selected before erase start (code does not check sector_select_bits at erase start)
// RULE24: supply drop aborts to read mode
// RULE25: operation durations are parameters
// RULE26: zero or multiple selects flags fault
`default_nettype none
module fwc_seq
  import fwc_pkg::*;
#(
  parameter int PROG_CYCLES = FWC_PROG_CYC,
  parameter int ERASE_CYCLES = FWC_ERASE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [23:0] bus_addr,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bank_rdata,
  input wire logic [15:0] ext_reg_rdata,
  input wire logic [23:0] target_address,
  input wire logic [7:0] sector_select_bits,
  input wire logic fault_flag,
  input wire logic bootstrap_mode,
  input wire logic supply_low,
  output logic [15:0] bus_rdata,
  output logic bus_trap,
  output logic bank_write_en,
  output logic ext_reg_write_en,
  output logic fault_update_en,
  output logic order_fault_flag,
  output logic [7:0] cell_pattern,
  output logic bank_busy_flag,
  output logic register_lock_flag
);
  fwc_state_t state_r, state_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic busy_r, busy_nxt, lock_r, lock_nxt;
  logic [3:0] run_sel_r, run_sel_nxt, pend_sel_r, pend_sel_nxt;
  logic seq_err_r, seq_err_nxt, preprog_r, preprog_nxt;
  logic [15:0] rdata_nxt;
  logic trap_nxt;
  logic sup_a_r, sup_b_r, sup_c_r, sup_low_r;
  logic tmr_load, tmr_done;
  logic [FWC_CNT_W-1:0] tmr_count;

  // ==========================================
  // Address decode
  wire in_bank = bus_addr <= FWC_BANK_HI;
  wire in_test = bus_addr <= FWC_TEST_HI;
  wire in_regs = bus_addr >= FWC_REG_WIN_LO && bus_addr <= FWC_REG_WIN_HI;
  wire hit_stat = in_regs && bus_addr[23:1] == FWC_STATUS_LOW_ADDR[23:1];
  wire hit_ctrl = in_regs && bus_addr[23:1] == FWC_OP_CONTROL_ADDR[23:1];
  wire hit_ext = in_regs && !hit_stat && !hit_ctrl;
  // Test sector never writable; its reads are not hidden outside bootstrap
  wire test_hit = in_test && bootstrap_mode; // see RULE9
  wire wr_ok = bus_req && bus_wr;
  wire rd_ok = bus_req && !bus_wr;
  wire ctrl_wr = wr_ok && hit_ctrl && bus_be[1] && !lock_r; // see RULE5
  wire [3:0] sel_w = {bus_wdata[FWC_WPG_BIT], bus_wdata[FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT],
                      bus_wdata[FWC_SER_BIT], bus_wdata[FWC_SPR_BIT]};
  wire start_w = ctrl_wr && bus_wdata[FWC_START_BIT];
  // Pause passes the lock, else no running operation could be suspended
  wire pause_w = wr_ok && hit_ctrl && bus_be[1] && bus_wdata[FWC_PAUSE_BIT]; // see RULE16
  wire one_hot = sel_w != 4'h0 && (sel_w & (sel_w - 4'h1)) == 4'h0;
  wire is_prog = sel_w[3] || sel_w[2];
  // Protection window check, honoured as printed
  wire prot_bad = sel_w[0] &&
                  (target_address < FWC_PROT_LO || target_address > FWC_PROT_HI); // see RULE11
  // Start allowed per state; pause bit held blocks new starts
  wire state_ok = (state_r == FWC_IDLE) ||
                  (state_r == FWC_PAUSED && (sel_w == pend_sel_r || // see RULE19
                   (pend_sel_r[1] && is_prog))); // see RULE18
  wire start_ok = start_w && !fault_flag && one_hot && !prot_bad && // see RULE22
                  !ctrl_r[FWC_PAUSE_BIT] && !bus_wdata[FWC_PAUSE_BIT] && state_ok; // see RULE20
  wire start_bad = start_w && !start_ok && !fault_flag && (!one_hot || prot_bad); // see RULE26
  wire is_resume = start_ok && state_r == FWC_PAUSED && sel_w == pend_sel_r;
  wire is_nested = start_ok && state_r == FWC_PAUSED && !is_resume;
  wire can_pause = pause_w && state_r == FWC_RUN && !run_sel_r[0]; // see RULE16
  wire pre_done = tmr_done && preprog_r && state_r == FWC_RUN; // Erase only, never nested

  // ==========================================
  // Supply-drop pin: three flops, second and third must agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sup_a_r <= 1'b0;
      sup_b_r <= 1'b0;
      sup_c_r <= 1'b0;
      sup_low_r <= 1'b0;
    end else begin
      sup_a_r <= supply_low;
      sup_b_r <= sup_a_r;
      sup_c_r <= sup_b_r;
      sup_low_r <= (sup_b_r == sup_c_r) ? sup_c_r : sup_low_r;
    end
  end

  // ==========================================
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    lock_nxt = lock_r;
    run_sel_nxt = run_sel_r;
    pend_sel_nxt = pend_sel_r;
    preprog_nxt = preprog_r;
    seq_err_nxt = start_bad ? 1'b1 : (ctrl_wr ? 1'b0 : seq_err_r);
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      // Pause bit and selects are software-held; start only by hardware
      ctrl_nxt[FWC_PAUSE_BIT] = bus_wdata[FWC_PAUSE_BIT];
      ctrl_nxt[FWC_WPG_BIT] = bus_wdata[FWC_WPG_BIT];
      ctrl_nxt[FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT] = bus_wdata[FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT];
      ctrl_nxt[FWC_SER_BIT] = bus_wdata[FWC_SER_BIT];
      ctrl_nxt[FWC_SPR_BIT] = bus_wdata[FWC_SPR_BIT];
    end
    case (state_r)
      FWC_IDLE: begin
        if (start_ok) begin
          state_nxt = FWC_RUN;
          busy_nxt = 1'b1; // see RULE1 RULE2
          lock_nxt = 1'b1; // see RULE6
          run_sel_nxt = sel_w;
          preprog_nxt = sel_w[1]; // see RULE13
          ctrl_nxt[FWC_START_BIT] = 1'b1;
        end
      end
      FWC_RUN, FWC_NEST: begin
        if (pre_done) begin
          preprog_nxt = 1'b0;
        end else if (tmr_done) begin
          // Completion: drop busy, lock, start and select
          state_nxt = (state_r == FWC_NEST) ? FWC_PAUSED : FWC_IDLE;
          busy_nxt = 1'b0; // see RULE4
          lock_nxt = 1'b0;
          ctrl_nxt[FWC_START_BIT] = 1'b0; // see RULE21
          ctrl_nxt[FWC_WPG_BIT] = 1'b0; // see RULE10 RULE12 RULE14 RULE15
          ctrl_nxt[FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT] = 1'b0;
          ctrl_nxt[FWC_SER_BIT] = 1'b0;
          ctrl_nxt[FWC_SPR_BIT] = 1'b0;
        end else if (can_pause && state_r == FWC_RUN) begin
          state_nxt = FWC_PAUSED;
          busy_nxt = 1'b0; // see RULE4 RULE16
          lock_nxt = 1'b0;
          pend_sel_nxt = run_sel_r;
          ctrl_nxt[FWC_PAUSE_BIT] = 1'b1;
          ctrl_nxt[FWC_START_BIT] = 1'b0; // see RULE21
        end
      end
      FWC_PAUSED: begin
        // Only resume, a program during erase pause, or a supply drop leaves here
        if (start_ok) begin
          state_nxt = is_resume ? FWC_RUN : FWC_NEST; // see RULE17
          busy_nxt = 1'b1; // see RULE4
          lock_nxt = 1'b1;
          run_sel_nxt = sel_w;
          ctrl_nxt[FWC_START_BIT] = 1'b1;
          if (is_resume) begin
            pend_sel_nxt = 4'h0;
          end
        end
      end
      default: begin
        state_nxt = FWC_IDLE;
      end
    endcase
    if (sup_low_r) begin
      // Supply drop wins over everything: back to read mode
      state_nxt = FWC_IDLE; // see RULE24
      busy_nxt = 1'b0;
      lock_nxt = 1'b0;
      preprog_nxt = 1'b0;
      pend_sel_nxt = 4'h0;
      ctrl_nxt = FWC_OP_CONTROL_RST;
    end
  end

  // ==========================================
  // Duration timer; a resume or nested program reloads it in full
  assign tmr_load = start_ok || pre_done;
  assign tmr_count = (start_ok ? sel_w[1] : run_sel_r[1]) ?
                     FWC_CNT_W'(ERASE_CYCLES) : FWC_CNT_W'(PROG_CYCLES); // see RULE25
  fwc_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(tmr_load),
    .hold(state_r == FWC_PAUSED || state_r == FWC_IDLE),
    .count(tmr_count),
    .done(tmr_done)
  );

  // ==========================================
  // Read data and trap
  wire [15:0] stat_word = {11'h000, lock_r, 2'b00, busy_r, 1'b0};
  wire bank_block = busy_r && in_bank; // see RULE3
  wire reg_block = lock_r && hit_ext; // see RULE5
  wire ctrl_block = lock_r && hit_ctrl;
  always_comb begin
    rdata_nxt = 16'h0000;
    trap_nxt = 1'b0;
    if (rd_ok) begin
      if (hit_stat) begin
        rdata_nxt = stat_word; // see RULE7
      end else if (bank_block || reg_block || ctrl_block) begin
        rdata_nxt = FWC_TRAP_CODE;
        trap_nxt = 1'b1;
      end else if (hit_ctrl) begin
        rdata_nxt = ctrl_r;
      end else if (hit_ext) begin
        rdata_nxt = ext_reg_rdata;
      end else if (in_bank) begin
        rdata_nxt = bank_rdata;
      end
    end
  end
  // Writes pass only when not guarded
  assign bank_write_en = wr_ok && in_bank && !busy_r && !test_hit && !in_test; // see RULE3 RULE9
  assign ext_reg_write_en = wr_ok && hit_ext && !lock_r; // see RULE5
  assign fault_update_en = !busy_r; // see RULE8
  assign cell_pattern = (preprog_r && state_r == FWC_RUN) ? FWC_PREPROG : FWC_ERASED; // see RULE13

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= FWC_IDLE;
      ctrl_r <= FWC_OP_CONTROL_RST;
      busy_r <= 1'b0;
      lock_r <= 1'b0;
      run_sel_r <= 4'h0;
      pend_sel_r <= 4'h0;
      preprog_r <= 1'b0;
      seq_err_r <= 1'b0;
      bus_rdata <= 16'h0000;
      bus_trap <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      busy_r <= busy_nxt;
      lock_r <= lock_nxt;
      run_sel_r <= run_sel_nxt;
      pend_sel_r <= pend_sel_nxt;
      preprog_r <= preprog_nxt;
      seq_err_r <= seq_err_nxt;
      bus_rdata <= rdata_nxt;
      bus_trap <= trap_nxt;
    end
  end
  assign order_fault_flag = seq_err_r;
  assign bank_busy_flag = busy_r;
  assign register_lock_flag = lock_r;
  wire unused_ok = ^sector_select_bits; // Sector selects are not used by any logic; only tied off here

  // ==========================================
  // Checks
  a_start_sets_busy: assert property (@(posedge clk) disable iff (!rstn) // see RULE1
    start_ok && state_r == FWC_IDLE && !sup_low_r |=> busy_r && lock_r)
    else $error("busy or lock missing after start");
  a_fault_blocks: assert property (@(posedge clk) disable iff (!rstn) // see RULE22
    state_r == FWC_IDLE && fault_flag |=> state_r == FWC_IDLE)
    else $error("start accepted with fault set");
  a_bank_trap: assert property (@(posedge clk) disable iff (!rstn) // see RULE3
    rd_ok && busy_r && in_bank |=> bus_trap && bus_rdata == FWC_TRAP_CODE)
    else $error("busy bank read not trapped");
  a_status_open: assert property (@(posedge clk) disable iff (!rstn) // see RULE7
    rd_ok && hit_stat |=> !bus_trap)
    else $error("status read trapped");
  a_bad_select: assert property (@(posedge clk) disable iff (!rstn) // see RULE26
    start_w && !one_hot && !fault_flag |=> seq_err_r && !$rose(busy_r))
    else $error("bad select not flagged");
  a_pause_drops: assert property (@(posedge clk) disable iff (!rstn) // see RULE16
    can_pause && !tmr_done && !sup_low_r |=> !busy_r && state_r == FWC_PAUSED)
    else $error("pause did not release bank");
  a_supply_abort: assert property (@(posedge clk) disable iff (!rstn) // see RULE24
    sup_low_r |=> state_r == FWC_IDLE && !busy_r)
    else $error("supply drop not aborting");
  a_lock_wr_block: assert property (@(posedge clk) disable iff (!rstn) // see RULE5
    lock_r |-> !ext_reg_write_en && !ctrl_wr)
    else $error("register write during lock");
  a_fault_hold: assert property (@(posedge clk) disable iff (!rstn) // see RULE8
    busy_r |-> !fault_update_en)
    else $error("fault update while busy");
  a_ctrl_trap: assert property (@(posedge clk) disable iff (!rstn) // see RULE5
    rd_ok && lock_r && hit_ctrl |=> bus_trap && bus_rdata == FWC_TRAP_CODE)
    else $error("locked control read not trapped");
  a_test_no_write: assert property (@(posedge clk) disable iff (!rstn) // see RULE9
    in_test |-> !bank_write_en)
    else $error("test sector write passed");
  a_done_clears: assert property (@(posedge clk) disable iff (!rstn) // see RULE4 RULE15
    state_r == FWC_RUN && tmr_done && !preprog_r && !sup_low_r |=>
    !busy_r && !lock_r && !ctrl_r[FWC_START_BIT] &&
    !ctrl_r[FWC_WPG_BIT] && !ctrl_r[FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT] && !ctrl_r[FWC_SER_BIT])
    else $error("completion left busy, lock or control bits");
  a_nest_stays: assert property (@(posedge clk) disable iff (!rstn) // see RULE18
    state_r == FWC_NEST && !tmr_done && !sup_low_r |=> state_r == FWC_NEST && busy_r)
    else $error("nested program left early");
  a_prog_refuse: assert property (@(posedge clk) disable iff (!rstn) // see RULE17
    state_r == FWC_PAUSED && !pend_sel_r[1] && start_w && sel_w != pend_sel_r |=> !busy_r)
    else $error("operation started during program pause");
  a_prot_fault: assert property (@(posedge clk) disable iff (!rstn) // see RULE11
    start_w && sel_w == 4'h1 && prot_bad && !fault_flag |=> seq_err_r && !busy_r)
    else $error("protection address not flagged");
  a_pause_clears_start: assert property (@(posedge clk) disable iff (!rstn) // see RULE21
    can_pause && !tmr_done && !sup_low_r |=> !ctrl_r[FWC_START_BIT] && ctrl_r[FWC_PAUSE_BIT])
    else $error("start bit kept on pause");
  a_resume_busy: assert property (@(posedge clk) disable iff (!rstn) // see RULE4
    is_resume && !sup_low_r |=> busy_r && state_r == FWC_RUN)
    else $error("resume did not raise busy");
  a_preprog_start: assert property (@(posedge clk) disable iff (!rstn) // see RULE13
    start_ok && state_r == FWC_IDLE && sel_w[1] && !sup_low_r |=> cell_pattern == FWC_PREPROG)
    else $error("erase did not preprogram");
  c_program_done: cover property (@(posedge clk) disable iff (!rstn)
    $fell(busy_r) && state_r == FWC_IDLE);
  c_erase_pause: cover property (@(posedge clk) disable iff (!rstn)
    state_r == FWC_PAUSED && pend_sel_r[1]);
  c_nested_prog: cover property (@(posedge clk) disable iff (!rstn)
    state_r == FWC_NEST);
  c_prog_pause: cover property (@(posedge clk) disable iff (!rstn)
    state_r == FWC_PAUSED && pend_sel_r[3]);
  c_supply_drop: cover property (@(posedge clk) disable iff (!rstn)
    $rose(sup_low_r));
endmodule
`default_nettype wire

// File: fwc_testbench.sv
// Self-checking bench for the flash write control sequencer
`default_nettype none
module testbench
  import fwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Long enough that every status check lands while the operation still runs
  localparam int PC = 16;
  localparam logic [23:0] DREG = 24'h080008;
  localparam logic [23:0] BADR = 24'h010000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_req = 1'b0;
  logic bus_wr = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  logic [1:0] bus_be = 2'b11;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bank_rdata = 16'h0000;
  logic [15:0] ext_reg_rdata = 16'h1234;
  logic [23:0] target_address = 24'h010000;
  logic [7:0] sector_select_bits = 8'h01;
  logic fault_flag = 1'b0;
  logic bootstrap_mode = 1'b0;
  logic supply_low = 1'b0;
  logic [15:0] bus_rdata, rd;
  logic [7:0] cell_pattern;
  logic bus_trap, bank_write_en, ext_reg_write_en, fault_update_en, order_fault_flag;
  logic bank_busy_flag, register_lock_flag, tr, we_b, we_x;
  logic [15:0] lf = 16'h002b;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;

  fwc_seq #(.PROG_CYCLES(PC), .ERASE_CYCLES(PC)) fwc_seq_inst (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bank_rdata(bank_rdata),
    .ext_reg_rdata(ext_reg_rdata), .target_address(target_address),
    .sector_select_bits(sector_select_bits), .fault_flag(fault_flag),
    .bootstrap_mode(bootstrap_mode), .supply_low(supply_low), .bus_rdata(bus_rdata),
    .bus_trap(bus_trap), .bank_write_en(bank_write_en), .ext_reg_write_en(ext_reg_write_en),
    .fault_update_en(fault_update_en), .order_fault_flag(order_fault_flag),
    .cell_pattern(cell_pattern), .bank_busy_flag(bank_busy_flag),
    .register_lock_flag(register_lock_flag));

  // =====================================================
  // Clock, timeout and expectation helpers
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Status word as software should see it
  function automatic logic [15:0] stat(input logic b, input logic l);
    stat = 16'h0000;
    stat[FWC_BUSY_BIT] = b;
    stat[FWC_LOCK_BIT] = l;
  endfunction

  // Start bit together with one operation select
  function automatic logic [15:0] go(input int sel);
    go = 16'h0000;
    go[FWC_START_BIT] = 1'b1;
    go[sel] = 1'b1;
  endfunction

  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // =====================================================
  // Bus access: one idle edge first, so a request never rises where one fell
  task automatic bus(input logic w, input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    bus_req = 1'b1;
    bus_wr = w;
    bus_addr = a;
    bus_wdata = d;
    #1;
    we_b = bank_write_en;
    we_x = ext_reg_write_en;
    @(posedge clk);
    #2;
    bus_req = 1'b0;
    rd = bus_rdata;
    tr = bus_trap;
  endtask

  // Bounded wait for the bank to go idle
  task automatic wait_idle();
    for (int i = 0; i < 3 * PC + 10 && bank_busy_flag !== 1'b0; i++) begin
      @(posedge clk);
      #2;
    end
    chk1("busy_end", 1'b0, bank_busy_flag);
    chk1("lock_end", 1'b0, register_lock_flag);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // =====================================================
  // Main sequence
  initial begin
    int sels[3];
    int refused[3];
    sels = '{FWC_WPG_BIT, FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT, FWC_SER_BIT};
    repeat (8) @(posedge clk);
    #2;
    rstn = 1'b1;
    bus(1'b0, FWC_STATUS_LOW_ADDR, 16'h0000);
    chk16("status_rst", FWC_STATUS_LOW_RST, rd);
    bus(1'b0, FWC_OP_CONTROL_ADDR, 16'h0000);
    chk16("control_rst", FWC_OP_CONTROL_RST, rd);
    $display("test reset done");
    // Word program, double word program and sector erase: locked access, bank guard, self-clearing control
    foreach (sels[k]) begin
      bus(1'b1, FWC_OP_CONTROL_ADDR, go(sels[k]));
      chk1("busy", 1'b1, bank_busy_flag);
      chk1("lock", 1'b1, register_lock_flag);
      chk1("fault_upd", 1'b0, fault_update_en);
      if (sels[k] == FWC_SER_BIT) chk16("preprog", {8'h00, FWC_PREPROG}, {8'h00, cell_pattern});
      bus(1'b0, FWC_STATUS_LOW_ADDR, 16'h0000);
      chk16("status_run", stat(1'b1, 1'b1), rd);
      bus(1'b0, FWC_OP_CONTROL_ADDR, 16'h0000);
      chk1("ctl_trap", 1'b1, tr);
      bus(1'b1, DREG, 16'h5555);
      chk1("reg_we_lock", 1'b0, we_x);
      bus(1'b0, BADR, 16'h0000);
      chk1("bank_trap", 1'b1, tr);
      bus(1'b1, BADR, 16'h0000);
      chk1("bank_we_busy", 1'b0, we_b);
      wait_idle();
      chk1("fault_upd_idle", 1'b1, fault_update_en);
      chk16("erased", {8'h00, FWC_ERASED}, {8'h00, cell_pattern});
      bus(1'b0, FWC_OP_CONTROL_ADDR, 16'h0000);
      chk16("ctl_cleared", 16'h0000, rd);
    end
    $display("test operations done");
    // Refused starts: no select, two selects, protection address out of window
    refused = '{16'h8000, 16'hb000, go(FWC_SPR_BIT)};
    foreach (refused[k]) begin
      bus(1'b1, FWC_OP_CONTROL_ADDR, refused[k][15:0]);
      chk1("refused_busy", 1'b0, bank_busy_flag);
      chk1("order_fault", 1'b1, order_fault_flag);
      bus(1'b1, FWC_OP_CONTROL_ADDR, 16'h0000);
    end
    fault_flag = 1'b1;
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_WPG_BIT));
    chk1("fault_block", 1'b0, bank_busy_flag);
    fault_flag = 1'b0;
    $display("test refusals done");
    // Erase pause, program inside it, erase resume
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_SER_BIT));
    bus(1'b1, FWC_OP_CONTROL_ADDR, 16'h4800);
    chk1("erase_paused", 1'b0, bank_busy_flag);
    bus(1'b1, FWC_OP_CONTROL_ADDR, 16'h0000);
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_WPG_BIT));
    chk1("prog_in_pause", 1'b1, bank_busy_flag);
    wait_idle();
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_SER_BIT));
    chk1("erase_resume", 1'b1, bank_busy_flag);
    wait_idle();
    // Program pause refuses an erase, then resumes
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_WPG_BIT));
    bus(1'b1, FWC_OP_CONTROL_ADDR, 16'h6000);
    chk1("prog_paused", 1'b0, bank_busy_flag);
    bus(1'b1, FWC_OP_CONTROL_ADDR, 16'h0000);
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_SER_BIT));
    chk1("erase_refused", 1'b0, bank_busy_flag);
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_WPG_BIT));
    chk1("prog_resume", 1'b1, bank_busy_flag);
    wait_idle();
    $display("test pause done");
    // Supply drop mid-program: synchroniser delay plus margin
    bus(1'b1, FWC_OP_CONTROL_ADDR, go(FWC_DOUBLE_WORD_PROGRAM_SELECT_BIT));
    supply_low = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    chk1("supply_abort", 1'b0, bank_busy_flag);
    supply_low = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    $display("test supply done");
    // Random idle traffic: bank and register reads pass, test sector stays shut
    bootstrap_mode = 1'b1;
    bus(1'b1, 24'h000100, 16'h0000);
    chk1("test_sector_we", 1'b0, we_b);
    bootstrap_mode = 1'b0;
    repeat (20) begin
      lf = lfsr(lf);
      bank_rdata = lf;
      ext_reg_rdata = ~lf;
      sector_select_bits = lf[7:0];
      target_address = {8'h01, lf};
      bus(1'b0, BADR | {8'h00, lf[15:1], 1'b0}, 16'h0000);
      chk16("bank_read", lf, rd);
      chk1("bank_no_trap", 1'b0, tr);
      bus(1'b1, DREG, lf);
      chk1("reg_we_idle", 1'b1, we_x);
      bus(1'b0, DREG, 16'h0000);
      chk16("reg_read", ~lf, rd);
    end
    $display("test random done");
    complete_run();
  end
endmodule
`default_nettype wire

// File: fwc_timer.sv
// Operation duration counter for the flash write sequencer
`default_nettype none
module fwc_timer
  import fwc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic hold,
  input wire logic [FWC_CNT_W-1:0] count,
  output logic done
);
  logic [FWC_CNT_W-1:0] cnt_r;
  logic [FWC_CNT_W-1:0] cnt_nxt;
  // ==========================================
  // Countdown, frozen while held
  assign cnt_nxt = load ? count :
                   (hold || cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
  // Done must not look at load: the parent derives load from done
  assign done = (cnt_r == {{(FWC_CNT_W-1){1'b0}}, 1'b1}) && !hold;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire
